/* File: addr_mode_decoder.sv */
// addr_mode_decoder: fetches prefix, opcode and operand bytes and forms addresses
// assumes memData holds the read byte by the edge that ends the memRd pulse
`timescale 1ns/100ps
// Notes on behaviour
// - inherent instructions are one opcode byte, nothing more fetched.
// - immediate fetches one operand byte used as the value.
// - short direct fetches one address byte, zero page.
// - long direct fetches a two-byte address, full space.
// - indexed address is unsigned sum of index and offset.
// - no-offset indexed uses the index register alone.
// - short indexed adds a one-byte offset, up to 1FE.
// - long indexed adds a two-byte offset, full space.
// - indirect fetches pointer address then reads pointer from memory.
// - short pointer is one byte, long pointer two bytes.
// - indirect indexed adds index to the pointer read.
// - relative adds a signed 8-bit offset to the program counter.
// - direct relative offset follows opcode; indirect reads it from memory.
// - an instruction spans one to four bytes including prefix.
// - prefix 90 swaps X for Y.
// - prefix 92 converts direct and offset X indexed forms to indirect.
// - prefix 91 makes X indirect indexed into Y indirect indexed.
// - an undefined byte that is not a prefix resets the device only when no prefix came before it.
// - valid prefix with valid opcode never raises the illegal reset.
// - the instruction set has 63 instructions in ten groups.
// - halt stops the oscillator; wait sleeps until an interrupt.
// - relative base is the address after the jump instruction.
module addr_mode_decoder
   import decoder_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] memData,
   input wire logic [7:0] regX,
   input wire logic [7:0] regY,
   input wire logic irqPending,
   output logic [15:0] memAddr,
   output logic memRd,
   output logic [15:0] effAddr,
   output logic [7:0] immValue,
   output logic [7:0] opcodeOut,
   output logic useY,
   output logic decodeDone,
   output logic illegalReset,
   output logic oscStop,
   output logic lowPower
);
   typedef enum logic [3:0] {
      S_FETCH, S_OPWAIT, S_B1, S_B2, S_PTR, S_PTR2, S_DONE, S_HALT, S_WAIT
   } state_e;

   state_e state_ff;
   logic [15:0] pc_ff;
   logic [7:0] op_ff;
   logic yPre_ff;
   logic yIndPre_ff;
   logic indPre_ff;
   logic [7:0] hiByte_ff;
   logic [7:0] ptrAddr_ff;
   logic [15:0] memAddr_ff;
   logic memRd_ff;
   logic [15:0] effAddr_ff;
   logic [7:0] imm_ff;
   logic done_ff;
   logic ill_ff;
   logic useY_ff;
   logic oscStop_ff;
   logic lowPower_ff;
   logic [15:0] instrStart_ff;
   mode_e mode;
   mode_e curMode;
   logic [7:0] idx;
   logic anyPre;

   opcode_classifier u_class (
      .opcode(memData),
      .indirectPre(indPre_ff | yIndPre_ff),
      .mode(mode)
   );
   opcode_classifier u_classHeld (
      .opcode(op_ff),
      .indirectPre(indPre_ff | yIndPre_ff),
      .mode(curMode)
   );

   function automatic logic isPrefix(input logic [7:0] b);
      isPrefix = (b == Y_SWAP_PREFIX) || (b == Y_INDIRECT_PREFIX) || (b == INDIRECT_PREFIX);
   endfunction

   assign anyPre = yPre_ff | yIndPre_ff | indPre_ff;
   assign idx = (yPre_ff | yIndPre_ff) ? regY : regX;

   function automatic logic [15:0] relTarget(input logic [15:0] pc, input logic [7:0] off);
      relTarget = pc + {{8{off[7]}}, off};
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= S_FETCH;
         pc_ff <= RESET_PC;
         op_ff <= 8'h00;
         yPre_ff <= 1'b0;
         yIndPre_ff <= 1'b0;
         indPre_ff <= 1'b0;
         hiByte_ff <= 8'h00;
         ptrAddr_ff <= 8'h00;
         memAddr_ff <= RESET_PC;
         memRd_ff <= 1'b0;
         effAddr_ff <= 16'h0000;
         imm_ff <= 8'h00;
         done_ff <= 1'b0;
         ill_ff <= 1'b0;
         useY_ff <= 1'b0;
         oscStop_ff <= 1'b0;
         lowPower_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         ill_ff <= 1'b0;
         memRd_ff <= 1'b0;
         case (state_ff)
            S_FETCH: begin
               memAddr_ff <= pc_ff;
               memRd_ff <= 1'b1;
               pc_ff <= pc_ff + 16'h0001;
               state_ff <= S_OPWAIT;
            end
            S_OPWAIT: begin
               if (isPrefix(memData) && !anyPre) begin
                  yPre_ff <= (memData == Y_SWAP_PREFIX);
                  yIndPre_ff <= (memData == Y_INDIRECT_PREFIX);
                  indPre_ff <= (memData == INDIRECT_PREFIX);
                  state_ff <= S_FETCH;
               end else if (mode == M_ILL && !anyPre) begin
                  ill_ff <= 1'b1;
                  state_ff <= S_FETCH;
               end else begin
                  // a prefixed combination never triggers the reset
                  op_ff <= memData;
                  useY_ff <= yPre_ff | yIndPre_ff;
                  if (mode == M_INH || mode == M_ILL) begin
                     effAddr_ff <= 16'h0000;
                     state_ff <= S_DONE;
                  end else if (mode == M_IDX0) begin
                     effAddr_ff <= {8'h00, idx};
                     state_ff <= S_DONE;
                  end else begin
                     memAddr_ff <= pc_ff;
                     memRd_ff <= 1'b1;
                     pc_ff <= pc_ff + 16'h0001;
                     state_ff <= S_B1;
                  end
               end
            end
            S_B1: begin
               case (curMode)
                  M_IMM: begin
                     imm_ff <= memData;
                     state_ff <= S_DONE;
                  end
                  M_DIR_S: begin
                     effAddr_ff <= {8'h00, memData};
                     state_ff <= S_DONE;
                  end
                  M_IDX_S: begin
                     effAddr_ff <= {8'h00, memData} + {8'h00, idx};
                     state_ff <= S_DONE;
                  end
                  M_REL: begin
                     imm_ff <= memData;
                     effAddr_ff <= relTarget(pc_ff, memData);
                     state_ff <= S_DONE;
                  end
                  M_DIR_L, M_IDX_L: begin
                     hiByte_ff <= memData;
                     memAddr_ff <= pc_ff;
                     memRd_ff <= 1'b1;
                     pc_ff <= pc_ff + 16'h0001;
                     state_ff <= S_B2;
                  end
                  default: begin
                     // pointer address byte, then read the pointer
                     ptrAddr_ff <= memData;
                     memAddr_ff <= {8'h00, memData};
                     memRd_ff <= 1'b1;
                     state_ff <= S_PTR;
                  end
               endcase
            end
            S_B2: begin
               if (curMode == M_DIR_L) begin
                  effAddr_ff <= {hiByte_ff, memData};
               end else begin
                  effAddr_ff <= {hiByte_ff, memData} + {8'h00, idx};
               end
               state_ff <= S_DONE;
            end
            S_PTR: begin
               case (curMode)
                  M_IND_S: begin
                     effAddr_ff <= {8'h00, memData};
                     state_ff <= S_DONE;
                  end
                  M_INDX_S: begin
                     effAddr_ff <= {8'h00, memData} + {8'h00, idx};
                     state_ff <= S_DONE;
                  end
                  M_REL_IND: begin
                     imm_ff <= memData;
                     effAddr_ff <= relTarget(pc_ff, memData);
                     state_ff <= S_DONE;
                  end
                  default: begin
                     hiByte_ff <= memData;
                     memAddr_ff <= {8'h00, ptrAddr_ff + 8'h01};
                     memRd_ff <= 1'b1;
                     state_ff <= S_PTR2;
                  end
               endcase
            end
            S_PTR2: begin
               if (curMode == M_IND_L) begin
                  effAddr_ff <= {hiByte_ff, memData};
               end else begin
                  effAddr_ff <= {hiByte_ff, memData} + {8'h00, idx};
               end
               state_ff <= S_DONE;
            end
            S_DONE: begin
               done_ff <= 1'b1;
               yPre_ff <= 1'b0;
               yIndPre_ff <= 1'b0;
               indPre_ff <= 1'b0;
               if (op_ff == OP_HALT) begin
                  state_ff <= S_HALT;
                  oscStop_ff <= 1'b1;
                  lowPower_ff <= 1'b1;
               end else if (op_ff == OP_WAIT_FOR_IRQ) begin
                  state_ff <= S_WAIT;
                  lowPower_ff <= 1'b1;
               end else begin
                  state_ff <= S_FETCH;
               end
            end
            S_WAIT: begin
               if (irqPending) begin
                  state_ff <= S_FETCH;
                  lowPower_ff <= 1'b0;
               end
            end
            S_HALT: begin
               state_ff <= S_HALT;
            end
            default: state_ff <= S_FETCH;
         endcase
      end
   end

   assign memAddr = memAddr_ff;
   assign memRd = memRd_ff;
   assign effAddr = effAddr_ff;
   assign immValue = imm_ff;
   assign opcodeOut = op_ff;
   assign useY = useY_ff;
   assign decodeDone = done_ff;
   assign illegalReset = ill_ff;
   assign oscStop = oscStop_ff;
   assign lowPower = lowPower_ff;

   // start address of the instruction in flight, for the length check
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         instrStart_ff <= RESET_PC;
      end else if (state_ff == S_DONE || ill_ff) begin
         instrStart_ff <= pc_ff;
      end
   end

   AST_ILLEGAL_NO_PREFIX: assert property (@(posedge clk) disable iff (!rst_n)
      illegalReset |-> $past(state_ff) == S_OPWAIT && !$past(anyPre))
      else $error("illegal reset after prefix");
   AST_ILLEGAL_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_OPWAIT && !anyPre && !isPrefix(memData) && mode == M_ILL)
      |=> illegalReset)
      else $error("illegal opcode missed");
   AST_INHERENT_LEN: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_OPWAIT && !isPrefix(memData) && mode == M_INH)
      |=> state_ff == S_DONE && !memRd)
      else $error("inherent fetched operand");
   AST_IMM_LEN: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_OPWAIT && !isPrefix(memData) && mode == M_IMM)
      |=> memRd ##1 state_ff == S_DONE)
      else $error("immediate length wrong");
   AST_IDX0: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_OPWAIT && !isPrefix(memData) && mode == M_IDX0)
      |=> effAddr == {8'h00, $past(idx)})
      else $error("no offset address wrong");
   AST_DIR_S: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_B1 && curMode == M_DIR_S) |=> effAddr == {8'h00, $past(memData)})
      else $error("short direct wrong");
   AST_REL: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_B1 && curMode == M_REL)
      |=> effAddr == $past(pc_ff) + {{8{$past(memData[7])}}, $past(memData)})
      else $error("relative target wrong");
   AST_IDX_S: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_B1 && curMode == M_IDX_S)
      |=> effAddr == {8'h00, $past(memData)} + {8'h00, $past(idx)})
      else $error("short indexed wrong");
   AST_PREFIX_Y: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_OPWAIT && !anyPre && memData == Y_SWAP_PREFIX) |=> yPre_ff)
      else $error("y prefix lost");
   AST_HALT: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_DONE && op_ff == OP_HALT) |=> oscStop [*3])
      else $error("halt left");
   AST_DIR_L: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_B2 && curMode == M_DIR_L) |=> effAddr == {$past(hiByte_ff), $past(memData)})
      else $error("long direct wrong");
   AST_IDX_L: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_B2 && curMode == M_IDX_L)
      |=> effAddr == {$past(hiByte_ff), $past(memData)} + {8'h00, $past(idx)})
      else $error("long indexed wrong");
   AST_IND_S: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_PTR && curMode == M_IND_S) |=> effAddr == {8'h00, $past(memData)})
      else $error("short indirect wrong");
   AST_IND_L: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_PTR2 && curMode == M_IND_L) |=> effAddr == {$past(hiByte_ff), $past(memData)})
      else $error("long indirect wrong");
   AST_INDX_S: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_PTR && curMode == M_INDX_S)
      |=> effAddr == {8'h00, $past(memData)} + {8'h00, $past(idx)})
      else $error("short indirect indexed wrong");
   AST_INDX_L: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_PTR2 && curMode == M_INDX_L)
      |=> effAddr == {$past(hiByte_ff), $past(memData)} + {8'h00, $past(idx)})
      else $error("long indirect indexed wrong");
   AST_PTR_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_PTR)
      |-> memRd && memAddr == {8'h00, ptrAddr_ff})
      else $error("pointer read address wrong");
   AST_PTR2_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_PTR2)
      |-> memRd && memAddr == {8'h00, ptrAddr_ff + 8'h01})
      else $error("pointer low byte address wrong");
   AST_REL_IND: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_PTR && curMode == M_REL_IND)
      |=> effAddr == $past(pc_ff) + {{8{$past(memData[7])}}, $past(memData)})
      else $error("indirect relative target wrong");
   AST_IMM_VALUE: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_B1 && curMode == M_IMM)
      |=> immValue == $past(memData))
      else $error("immediate value wrong");
   AST_PREFIX_IND: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_OPWAIT && !anyPre && memData == INDIRECT_PREFIX)
      |=> indPre_ff && state_ff == S_FETCH)
      else $error("indirect prefix lost");
   AST_PREFIX_YIND: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_OPWAIT && !anyPre && memData == Y_INDIRECT_PREFIX)
      |=> yIndPre_ff)
      else $error("y indirect prefix lost");
   AST_WAIT_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_WAIT && irqPending)
      |=> !lowPower && state_ff == S_FETCH)
      else $error("wait not left on interrupt");
   AST_INSTR_LEN: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == S_DONE)
      |-> pc_ff != instrStart_ff && (pc_ff - instrStart_ff) <= 16'h0004)
      else $error("instruction length out of range");
endmodule

/* File: cpu_addressing_mode_decoder_tb.sv */
// cpu_addressing_mode_decoder_tb: directed checks of fetch length and address forming
// assumes mem_model as program memory and the opcode map of the classifier
`timescale 1ns/100ps
module cpu_addressing_mode_decoder_tb;
   import decoder_pkg::*;
   localparam logic [7:0] OP_NOP = 8'h9D;
   localparam logic [7:0] OP_IMM = 8'hA6;
   localparam logic [7:0] OP_DIR = 8'hB6;
   localparam logic [7:0] OP_EXT = 8'hC6;
   localparam logic [7:0] OP_IXL = 8'hD6;
   localparam logic [7:0] OP_IXS = 8'hE6;
   localparam logic [7:0] OP_IX0 = 8'hF6;
   localparam logic [7:0] OP_JRA = 8'h20;
   localparam logic [7:0] OP_UNDEF = 8'h82;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] memData;
   logic [7:0] regX = 8'h00;
   logic [7:0] regY = 8'h00;
   logic irqPending = 1'b0;
   logic [15:0] memAddr, effAddr;
   logic memRd, useY, decodeDone, illegalReset, oscStop, lowPower;
   logic [7:0] immValue, opcodeOut;
   logic doneSeen;
   int readCount, illCount;
   int miscompares = 0;
   int totalChecks = 0;
   always #10 clk = ~clk;
   addr_mode_decoder i_dut (.clk(clk), .rst_n(rst_n), .memData(memData), .regX(regX),
      .regY(regY), .irqPending(irqPending), .memAddr(memAddr), .memRd(memRd),
      .effAddr(effAddr), .immValue(immValue), .opcodeOut(opcodeOut), .useY(useY),
      .decodeDone(decodeDone), .illegalReset(illegalReset), .oscStop(oscStop),
      .lowPower(lowPower));
   mem_model i_mem (.clk(clk), .memAddr(memAddr), .memRd(memRd), .memData(memData));
   // counts read pulses and illegal pulses since the last reset
   always @(posedge clk) begin
      if (rst_n === 1'b0) begin
         readCount <= 0;
         illCount <= 0;
      end else begin
         if (memRd === 1'b1) readCount <= readCount + 1;
         if (illegalReset === 1'b1) illCount <= illCount + 1;
      end
   end
   task check_addr(input string what, input logic [15:0] exp, input logic [15:0] got);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task check_bit(input string what, input logic exp, input logic got);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   // loads bytes at 0..3 and a pointer at 40/41, resets and waits for decodeDone
   task step(input logic [7:0] b0, b1, b2, b3, p0, p1, x, y);
      @(negedge clk);
      for (int i = 0; i < 256; i++) i_mem.put(8'(i), OP_NOP);
      i_mem.put(8'h00, b0);
      i_mem.put(8'h01, b1);
      i_mem.put(8'h02, b2);
      i_mem.put(8'h03, b3);
      i_mem.put(8'h40, p0);
      i_mem.put(8'h41, p1);
      rst_n = 1'b0;
      regX = x;
      regY = y;
      irqPending = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      doneSeen = 1'b0;
      for (int i = 0; i < 40 && !doneSeen; i++) begin
         @(posedge clk);
         #1;
         doneSeen = (decodeDone === 1'b1);
      end
   endtask
   task t_inherent_imm;
      step(OP_NOP, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check_bit("done", 1'b1, doneSeen);
      check_byte("opcode", OP_NOP, opcodeOut);
      check_byte("reads", 8'h01, 8'(readCount));
      check_byte("illegal", 8'h00, 8'(illCount));
      step(OP_IMM, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check_byte("imm", 8'h5A, immValue);
      check_byte("reads", 8'h02, 8'(readCount));
      $display("test inherent_imm done");
   endtask
   task t_direct;
      step(OP_DIR, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check_addr("eff", 16'h0055, effAddr);
      check_byte("reads", 8'h02, 8'(readCount));
      step(OP_EXT, 8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check_addr("eff", 16'h1234, effAddr);
      check_byte("reads", 8'h03, 8'(readCount));
      $display("test direct done");
   endtask
   task t_indexed;
      step(OP_IX0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00);
      check_addr("eff", 16'h00FF, effAddr);
      check_byte("reads", 8'h01, 8'(readCount));
      step(OP_IXS, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00);
      check_addr("eff", 16'h01FE, effAddr);
      step(OP_IXL, 8'h12, 8'h80, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h00);
      check_addr("eff", 16'h1370, effAddr);
      check_byte("reads", 8'h03, 8'(readCount));
      $display("test indexed done");
   endtask
   task t_indirect;
      step(INDIRECT_PREFIX, OP_DIR, 8'h40, 8'h00, 8'h77, 8'h00, 8'h00, 8'h00);
      check_addr("eff", 16'h0077, effAddr);
      check_byte("reads", 8'h04, 8'(readCount));
      step(INDIRECT_PREFIX, OP_EXT, 8'h40, 8'h00, 8'hAB, 8'hCD, 8'h00, 8'h00);
      check_addr("eff", 16'hABCD, effAddr);
      check_byte("reads", 8'h05, 8'(readCount));
      check_addr("ptr addr", 16'h0041, memAddr);
      step(INDIRECT_PREFIX, OP_IXS, 8'h40, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00);
      check_addr("eff", 16'h01FE, effAddr);
      step(INDIRECT_PREFIX, OP_IXL, 8'h40, 8'h00, 8'h12, 8'h34, 8'h05, 8'h00);
      check_addr("eff", 16'h1239, effAddr);
      step(Y_INDIRECT_PREFIX, OP_IXS, 8'h40, 8'h00, 8'h20, 8'h00, 8'h77, 8'h10);
      check_addr("eff", 16'h0030, effAddr);
      check_bit("useY", 1'b1, useY);
      $display("test indirect done");
   endtask
   task t_prefix_y;
      step(Y_SWAP_PREFIX, OP_IX0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h42);
      check_addr("eff", 16'h0042, effAddr);
      check_bit("useY", 1'b1, useY);
      step(Y_SWAP_PREFIX, OP_IMM, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check_byte("imm", 8'h33, immValue);
      check_bit("useY", 1'b1, useY);
      $display("test prefix_y done");
   endtask
   task t_relative;
      step(OP_JRA, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check_addr("target", 16'h0007, effAddr);
      check_byte("offset", 8'h05, immValue);
      step(OP_JRA, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check_addr("target", 16'hFFF2, effAddr);
      step(INDIRECT_PREFIX, OP_JRA, 8'h40, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00);
      check_addr("target", 16'h0013, effAddr);
      check_byte("reads", 8'h04, 8'(readCount));
      $display("test relative done");
   endtask
   task t_illegal;
      step(OP_UNDEF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check_bit("illegal", 1'b1, illCount != 0);
      step(INDIRECT_PREFIX, OP_UNDEF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check_bit("done", 1'b1, doneSeen);
      check_byte("illegal", 8'h00, 8'(illCount));
      $display("test illegal done");
   endtask
   task t_power;
      step(OP_HALT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      @(negedge clk);
      irqPending = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      check_bit("oscStop", 1'b1, oscStop);
      check_bit("lowPower", 1'b1, lowPower);
      step(OP_WAIT_FOR_IRQ, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check_bit("lowPower", 1'b1, lowPower);
      check_bit("oscStop", 1'b0, oscStop);
      @(negedge clk);
      irqPending = 1'b1;
      for (int i = 0; i < 10 && lowPower === 1'b1; i++) @(negedge clk);
      check_bit("lowPower", 1'b0, lowPower);
      $display("test power done");
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      tally_and_finish;
   end
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      t_inherent_imm;
      t_direct;
      t_indexed;
      t_indirect;
      t_prefix_y;
      t_relative;
      t_illegal;
      t_power;
      tally_and_finish;
   end
endmodule

/* File: decoder_pkg.sv */
// decoder_pkg: shared constants for the fetch and address decode front end
// assumes a byte-wide memory port with a one-cycle read answer
package decoder_pkg;
   localparam logic [7:0] Y_SWAP_PREFIX = 8'h90;
   localparam logic [7:0] Y_INDIRECT_PREFIX = 8'h91;
   localparam logic [7:0] INDIRECT_PREFIX = 8'h92;
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [7:0] OP_HALT = 8'h8E;
   localparam logic [7:0] OP_WAIT_FOR_IRQ = 8'h8F;
   localparam int INSTR_COUNT = 63;
   // addressing modes
   typedef enum logic [3:0] {
      M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX0, M_IDX_S, M_IDX_L,
      M_IND_S, M_IND_L, M_INDX_S, M_INDX_L, M_REL, M_REL_IND, M_ILL
   } mode_e;
   localparam int NUM_MODES = 14;
endpackage

/* File: mem_model.sv */
// mem_model: byte-wide program and data memory on the far side of the decoder
// assumes 256 bytes mirrored over the whole 64K space, answer mid-cycle while memRd stands
`timescale 1ns/100ps
module mem_model (
   input wire logic clk,
   input wire logic [15:0] memAddr,
   input wire logic memRd,
   output logic [7:0] memData
);
   logic [7:0] store [0:255];
   initial begin
      memData = 8'h00;
      for (int i = 0; i < 256; i++) begin
         store[i] = 8'h9D;
      end
   end
   task put(input logic [7:0] a, input logic [7:0] d);
      store[a] = d;
   endtask
   // read answer at the falling edge inside the pulse, a changing pattern otherwise
   always @(negedge clk) begin
      if (memRd === 1'b1) begin
         memData <= store[memAddr[7:0]];
      end else begin
         memData <= ~memData;
      end
   end
endmodule

/* File: opcode_classifier.sv */
// opcode_classifier: maps opcode plus prefix to an addressing mode
// assumes purely combinational use inside the fetch engine
`timescale 1ns/100ps
module opcode_classifier
   import decoder_pkg::*;
(
   input wire logic [7:0] opcode,
   input wire logic indirectPre,
   output mode_e mode
);
   logic [3:0] hi;
   logic [3:0] lo;
   mode_e baseMode;
   assign hi = opcode[7:4];
   assign lo = opcode[3:0];

   always_comb begin
      baseMode = M_ILL;
      case (hi)
         4'h0: baseMode = M_DIR_S;
         4'h1: baseMode = M_DIR_S;
         4'h2: baseMode = M_REL;
         4'h3: baseMode = M_DIR_S;
         4'h4, 4'h5, 4'h8, 4'h9: baseMode = M_INH;
         4'h6: baseMode = M_IDX_S;
         4'h7: baseMode = M_IDX0;
         4'hA: baseMode = (lo == 4'hD) ? M_REL : M_IMM;
         4'hB: baseMode = M_DIR_S;
         4'hC: baseMode = M_DIR_L;
         4'hD: baseMode = M_IDX_L;
         4'hE: baseMode = M_IDX_S;
         4'hF: baseMode = M_IDX0;
         default: baseMode = M_ILL;
      endcase
      // holes in the map
      if ((hi == 4'h8 && (lo == 4'h2 || lo == 4'h3 && 1'b0 || lo == 4'hC)) ||
          (hi == 4'h9 && lo == 4'h2) || (hi == 4'hA && lo == 4'h7) ||
          (hi == 4'h4 && (lo == 4'h5 || lo == 4'hE || lo == 4'h1)) ||
          (hi == 4'h3 && lo == 4'h5) || (hi == 4'h7 && lo == 4'h5)) begin
         baseMode = M_ILL;
      end
      mode = baseMode;
      if (indirectPre) begin
         case (baseMode)
            M_DIR_S: mode = M_IND_S;
            M_DIR_L: mode = M_IND_L;
            M_REL: mode = M_REL_IND;
            M_IDX_S: mode = M_INDX_S;
            M_IDX_L: mode = M_INDX_L;
            default: mode = baseMode;
         endcase
      end
   end
endmodule
